// >>> verilog/diom_top.sv
// general pin port with alternate-function multiplexing and apb registers
//
// Behaviour
// - the reset pin is active low both ways and the block pulls it low on internal reset.
// - a pin in its primary role is input or output as software direction says.
// - a pin takes a secondary role only when its peripheral is enabled, which overrides direction.
// - in a secondary role peripheral inputs are never driven and outputs always are, except the two-wire lines, driven only when pulling low.
// - each pull-up has its own enable, independent of role, all enabled after reset.
// - during reset all peripherals are off and every pin is an undriven input.
// - on sleep entry each pin's direction and level are held until wake-up.
// - an input pin with its interrupt enabled raises a wake-up request in sleep.
// - pins 2 and 3 carry serial selects three and four or radio receive and transmit control.
// - pins 4 to 7 carry first uart cts, rts, txd, rxd or jtag tck, tms, tdo, tdi.
// - pins 8 to 10 carry timer a gate or pulse count b, capture or slow clock, pwm or crystal.
// - pins 11 to 13 carry timer b gate or timer c pwm, capture, pwm, antenna and audio.
// - pins 14 to 16 carry the two-wire clock and data or the peripheral slave port.
// - pins 17 and 18 carry second uart flow, slave select and irq, audio or jtag.
// - pins 19 and 20 carry second uart txd and rxd or jtag tdo and tdi.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "diom_defines.svh"
module diom_top import diom_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic wake_req,
  output logic sleep_active,
  input wire logic int_reset_req,
  input wire logic reset_pin_low_in,
  output logic reset_pin_low_out,
  output logic reset_pin_low_oe,
  output logic ext_reset_seen,
  input wire logic [20:0] general_pin_in,
  output logic [20:0] general_pin_out,
  output logic [20:0] general_pin_oe,
  output logic [20:0] general_pin_pullup,
  input wire logic serial_select_three,
  input wire logic serial_select_four,
  input wire logic radio_receive_ctrl,
  input wire logic radio_transmit_ctrl,
  input wire logic uart_a_rts,
  input wire logic uart_a_txd,
  input wire logic jtag_tdo,
  input wire logic timer_a_pwm_out,
  input wire logic slow_crystal_out,
  input wire logic timer_c_pwm_out,
  input wire logic timer_b_pwm_out,
  input wire logic antenna_div_out,
  input wire logic antenna_div_enable,
  input wire logic audio_word_select,
  input wire logic audio_bit_clock,
  input wire logic audio_data_out,
  input wire logic two_wire_clock_oe,
  input wire logic two_wire_data_oe,
  input wire logic periph_slave_data_out,
  input wire logic periph_slave_irq,
  input wire logic uart_b_rts,
  input wire logic uart_b_txd,
  output logic uart_a_cts,
  output logic uart_a_rxd,
  output logic jtag_tck,
  output logic jtag_tms,
  output logic jtag_tdi,
  output logic timer_a_clock_gate,
  output logic pulse_count_b_in,
  output logic timer_a_capture,
  output logic slow_clock_in,
  output logic timer_b_clock_gate,
  output logic timer_b_capture,
  output logic audio_data_in,
  output logic two_wire_clock_in,
  output logic two_wire_data_in,
  output logic periph_slave_clock,
  output logic periph_slave_data_in,
  output logic periph_slave_select,
  output logic uart_b_cts,
  output logic uart_b_rxd
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and synchronisers
  diom_pins_t dir_ff, out_ff, pull_ff, ien_ff, stat_ff;
  logic [`DIOM_NFUNC-1:0] fen_ff;
  diom_pins_t sync1_ff, sync2_ff, prev_ff;
  diom_pins_t pin_out_ff, pin_oe_ff, nxt_pin_out, nxt_pin_oe, alt;
  logic [18:0] pi_ff, nxt_pi;
  logic rst1_ff, rst2_ff, swrst_ff, rstdrv_ff, wake_ff, irq_ff;
  diom_pwr_t pwr_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic acc, wr, sleeping;
  diom_pins_t ev, p, wake_src;

  assign acc = psel & penable & ~pready_ff;
  assign wr = acc & pwrite;
  assign sleeping = (pwr_ff == PS_SLEEP);
  assign p = sync2_ff;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
      rst1_ff <= 1'b1;
      rst2_ff <= 1'b0;
    end else begin
      sync1_ff <= general_pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      rst1_ff <= reset_pin_low_in;
      rst2_ff <= ~rst1_ff; // second stage holds a low pin as one, output stays a flop
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; enables off at reset so every peripheral is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= '0;
      out_ff <= '0;
      pull_ff <= `DIOM_PULL_RST;
      fen_ff <= '0;
      ien_ff <= '0;
      swrst_ff <= 1'b0;
    end else if (wr) begin
      if (hit(paddr, `DIOM_DIR_OFF)) dir_ff <= pwdata[20:0];
      if (hit(paddr, `DIOM_OUT_OFF)) out_ff <= pwdata[20:0];
      if (hit(paddr, `DIOM_PULL_OFF)) pull_ff <= pwdata[20:0];
      if (hit(paddr, `DIOM_FEN_OFF)) fen_ff <= pwdata[`DIOM_NFUNC-1:0];
      if (hit(paddr, `DIOM_IEN_OFF)) ien_ff <= pwdata[20:0];
      if (hit(paddr, `DIOM_CTRL_OFF)) swrst_ff <= pwdata[`DIOM_CTRL_SWRST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, unmapped offsets give pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & (paddr > `DIOM_CTRL_OFF || paddr[1:0] != 2'h0);
      prdata_ff <= '0;
      if (acc && !pwrite) begin
        case (paddr)
          `DIOM_DIR_OFF: prdata_ff <= {11'h0, dir_ff};
          `DIOM_OUT_OFF: prdata_ff <= {11'h0, out_ff};
          `DIOM_IN_OFF: prdata_ff <= {11'h0, p};
          `DIOM_PULL_OFF: prdata_ff <= {11'h0, pull_ff};
          `DIOM_FEN_OFF: prdata_ff <= {9'h0, fen_ff};
          `DIOM_IEN_OFF: prdata_ff <= {11'h0, ien_ff};
          `DIOM_STAT_OFF: prdata_ff <= {11'h0, stat_ff};
          `DIOM_CTRL_OFF: prdata_ff <= {30'h0, swrst_ff, sleeping};
          default: prdata_ff <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: rising edge of an input pin, set wins over clear
  assign ev = p & ~prev_ff & ~dir_ff;
  assign wake_src = stat_ff & ien_ff & ~dir_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~(wr && hit(paddr, `DIOM_CLR_OFF) ? pwdata[20:0] : 21'h0)) | ev;
      irq_ff <= |(stat_ff & ien_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep: entered by software, left on an enabled input event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= PS_RUN;
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= 1'b0;
      case (pwr_ff)
        PS_RUN: begin
          if (wr && hit(paddr, `DIOM_CTRL_OFF) && pwdata[`DIOM_CTRL_SLEEP]) pwr_ff <= PS_SLEEP;
        end
        PS_SLEEP: begin
          if (|wake_src) begin
            pwr_ff <= PS_RUN;
            wake_ff <= 1'b1;
          end
        end
        default: pwr_ff <= PS_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin: driven low while any internal source asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rstdrv_ff <= 1'b0;
    else rstdrv_ff <= int_reset_req | swrst_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // function multiplexer; earlier branches win a shared pin
  always_comb begin
    nxt_pin_oe = dir_ff;
    nxt_pin_out = out_ff;
    alt = '0;
    nxt_pi = '0;
    nxt_pi[PI_UA_CTS] = 1'b1;
    nxt_pi[PI_UA_RXD] = 1'b1;
    nxt_pi[PI_UB_CTS] = 1'b1;
    nxt_pi[PI_UB_RXD] = 1'b1;
    // pins 2 and 3
    if (fen_ff[`DIOM_F_SEL3]) begin
      alt[2] = 1'b1; nxt_pin_oe[2] = 1'b1; nxt_pin_out[2] = serial_select_three;
    end else if (fen_ff[`DIOM_F_RADIO]) begin
      alt[2] = 1'b1; nxt_pin_oe[2] = 1'b1; nxt_pin_out[2] = radio_receive_ctrl;
    end
    if (fen_ff[`DIOM_F_SEL4]) begin
      alt[3] = 1'b1; nxt_pin_oe[3] = 1'b1; nxt_pin_out[3] = serial_select_four;
    end else if (fen_ff[`DIOM_F_RADIO]) begin
      alt[3] = 1'b1; nxt_pin_oe[3] = 1'b1; nxt_pin_out[3] = radio_transmit_ctrl;
    end
    // pins 4 to 7; jtag here only if the first uart is off, the second site has its own enable
    if (fen_ff[`DIOM_F_UA]) begin
      alt[7:4] = 4'hf;
      nxt_pin_oe[7:4] = 4'h6;
      nxt_pin_out[5] = uart_a_rts;
      nxt_pin_out[6] = uart_a_txd;
      nxt_pi[PI_UA_CTS] = p[4];
      nxt_pi[PI_UA_RXD] = p[7];
    end else if (fen_ff[`DIOM_F_JTA]) begin
      alt[7:4] = 4'hf;
      nxt_pin_oe[7:4] = 4'h4;
      nxt_pin_out[6] = jtag_tdo;
      nxt_pi[PI_JTCK] = p[4];
      nxt_pi[PI_JTMS] = p[5];
      nxt_pi[PI_JTDI] = p[7];
    end
    // pins 8 to 10
    if (fen_ff[`DIOM_F_TAGATE]) begin
      alt[8] = 1'b1; nxt_pin_oe[8] = 1'b0; nxt_pi[PI_TA_GATE] = p[8];
    end else if (fen_ff[`DIOM_F_PCB]) begin
      alt[8] = 1'b1; nxt_pin_oe[8] = 1'b0; nxt_pi[PI_PCB] = p[8];
    end
    if (fen_ff[`DIOM_F_TACAP]) begin
      alt[9] = 1'b1; nxt_pin_oe[9] = 1'b0; nxt_pi[PI_TA_CAP] = p[9];
    end else if (fen_ff[`DIOM_F_SLOWX] | fen_ff[`DIOM_F_SLOWE]) begin
      alt[9] = 1'b1; nxt_pin_oe[9] = 1'b0; nxt_pi[PI_SLOW_IN] = p[9];
    end
    if (fen_ff[`DIOM_F_TAPWM]) begin
      alt[10] = 1'b1; nxt_pin_oe[10] = 1'b1; nxt_pin_out[10] = timer_a_pwm_out;
    end else if (fen_ff[`DIOM_F_SLOWX]) begin
      alt[10] = 1'b1; nxt_pin_oe[10] = 1'b1; nxt_pin_out[10] = slow_crystal_out;
    end
    // pins 11 to 13
    if (fen_ff[`DIOM_F_TBGATE]) begin
      alt[11] = 1'b1; nxt_pin_oe[11] = 1'b0; nxt_pi[PI_TB_GATE] = p[11];
    end else if (fen_ff[`DIOM_F_TCPWM]) begin
      alt[11] = 1'b1; nxt_pin_oe[11] = 1'b1; nxt_pin_out[11] = timer_c_pwm_out;
    end
    if (fen_ff[`DIOM_F_TBCAP]) begin
      alt[12] = 1'b1; nxt_pin_oe[12] = 1'b0; nxt_pi[PI_TB_CAP] = p[12];
    end else if (fen_ff[`DIOM_F_ANT]) begin
      alt[12] = 1'b1; nxt_pin_oe[12] = 1'b1; nxt_pin_out[12] = antenna_div_out;
    end else if (fen_ff[`DIOM_F_AUDIO]) begin
      alt[12] = 1'b1; nxt_pin_oe[12] = 1'b1; nxt_pin_out[12] = audio_word_select;
    end
    if (fen_ff[`DIOM_F_TBPWM]) begin
      alt[13] = 1'b1; nxt_pin_oe[13] = 1'b1; nxt_pin_out[13] = timer_b_pwm_out;
    end else if (fen_ff[`DIOM_F_ANT]) begin
      alt[13] = 1'b1; nxt_pin_oe[13] = 1'b1; nxt_pin_out[13] = antenna_div_enable;
    end else if (fen_ff[`DIOM_F_AUDIO]) begin
      alt[13] = 1'b1; nxt_pin_oe[13] = 1'b0; nxt_pi[PI_AUD_IN] = p[13];
    end
    // pins 14 to 16; two-wire lines are open drain, only ever pulled low
    if (fen_ff[`DIOM_F_TWI]) begin
      alt[15:14] = 2'h3;
      nxt_pin_out[15:14] = 2'h0;
      nxt_pin_oe[14] = two_wire_clock_oe;
      nxt_pin_oe[15] = two_wire_data_oe;
      nxt_pi[PI_TW_CLK] = p[14];
      nxt_pi[PI_TW_DAT] = p[15];
    end else if (fen_ff[`DIOM_F_PSLV]) begin
      alt[15:14] = 2'h3;
      nxt_pin_oe[15:14] = 2'h2;
      nxt_pin_out[15] = periph_slave_data_out;
      nxt_pi[PI_PS_CLK] = p[14];
    end
    if (fen_ff[`DIOM_F_PSLV]) begin
      alt[16] = 1'b1; nxt_pin_oe[16] = 1'b0; nxt_pi[PI_PS_DIN] = p[16];
    end
    // pins 17 and 18
    if (fen_ff[`DIOM_F_UBFLOW]) begin
      alt[18:17] = 2'h3; nxt_pin_oe[18:17] = 2'h2;
      nxt_pin_out[18] = uart_b_rts; nxt_pi[PI_UB_CTS] = p[17];
    end else if (fen_ff[`DIOM_F_PSLV]) begin
      alt[18:17] = 2'h3; nxt_pin_oe[18:17] = 2'h2;
      nxt_pin_out[18] = periph_slave_irq; nxt_pi[PI_PS_SEL] = p[17];
    end else if (fen_ff[`DIOM_F_AUDIO]) begin
      alt[18:17] = 2'h3; nxt_pin_oe[18:17] = 2'h3;
      nxt_pin_out[17] = audio_bit_clock; nxt_pin_out[18] = audio_data_out;
    end else if (fen_ff[`DIOM_F_JTB] && !fen_ff[`DIOM_F_JTA]) begin
      alt[18:17] = 2'h3; nxt_pin_oe[18:17] = 2'h0;
      nxt_pi[PI_JTCK] = p[17]; nxt_pi[PI_JTMS] = p[18];
    end
    // pins 19 and 20
    if (fen_ff[`DIOM_F_UB]) begin
      alt[20:19] = 2'h3; nxt_pin_oe[20:19] = 2'h1;
      nxt_pin_out[19] = uart_b_txd; nxt_pi[PI_UB_RXD] = p[20];
    end else if (fen_ff[`DIOM_F_JTB] && !fen_ff[`DIOM_F_JTA]) begin
      alt[20:19] = 2'h3; nxt_pin_oe[20:19] = 2'h1;
      nxt_pin_out[19] = jtag_tdo; nxt_pi[PI_JTDI] = p[20];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; frozen in sleep so the pads keep their last state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_ff <= '0;
      pin_out_ff <= '0;
      pi_ff <= `DIOM_PI_RST; // uart cts and rxd idle high, no false start bit
    end else begin
      if (!sleeping) begin
        pin_oe_ff <= nxt_pin_oe;
        pin_out_ff <= nxt_pin_out;
      end
      pi_ff <= nxt_pi;
    end
  end

  assign general_pin_out = pin_out_ff;
  assign general_pin_oe = pin_oe_ff;
  assign general_pin_pullup = pull_ff;
  assign reset_pin_low_out = 1'b0;
  assign reset_pin_low_oe = rstdrv_ff;
  assign ext_reset_seen = rst2_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign wake_req = wake_ff;
  assign sleep_active = (pwr_ff == PS_SLEEP);
  assign uart_a_cts = pi_ff[PI_UA_CTS];
  assign uart_a_rxd = pi_ff[PI_UA_RXD];
  assign jtag_tck = pi_ff[PI_JTCK];
  assign jtag_tms = pi_ff[PI_JTMS];
  assign jtag_tdi = pi_ff[PI_JTDI];
  assign timer_a_clock_gate = pi_ff[PI_TA_GATE];
  assign pulse_count_b_in = pi_ff[PI_PCB];
  assign timer_a_capture = pi_ff[PI_TA_CAP];
  assign slow_clock_in = pi_ff[PI_SLOW_IN];
  assign timer_b_clock_gate = pi_ff[PI_TB_GATE];
  assign timer_b_capture = pi_ff[PI_TB_CAP];
  assign audio_data_in = pi_ff[PI_AUD_IN];
  assign two_wire_clock_in = pi_ff[PI_TW_CLK];
  assign two_wire_data_in = pi_ff[PI_TW_DAT];
  assign periph_slave_clock = pi_ff[PI_PS_CLK];
  assign periph_slave_data_in = pi_ff[PI_PS_DIN];
  assign periph_slave_select = pi_ff[PI_PS_SEL];
  assign uart_b_cts = pi_ff[PI_UB_CTS];
  assign uart_b_rxd = pi_ff[PI_UB_RXD];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_asleep2;
    sleeping ##1 sleeping;
  endsequence

  a_reset_pin_drive: assert property (int_reset_req |=> reset_pin_low_oe)
    else $error("reset pin not driven low");
  a_gpio_dir_follow: assert property (!sleeping && !alt[0] |=> pin_oe_ff[0] == $past(dir_ff[0]))
    else $error("primary pin direction wrong");
  a_alt_uart_dir: assert property (!sleeping && fen_ff[`DIOM_F_UA] |=> pin_oe_ff[7:4] == 4'h6)
    else $error("uart pin directions wrong");
  a_alt_input_free: assert property (!sleeping && fen_ff[`DIOM_F_TBCAP] |=> !pin_oe_ff[12])
    else $error("peripheral input driven");
  a_pull_indep: assert property (wr && paddr != `DIOM_PULL_OFF |=> $stable(pull_ff))
    else $error("pull-up changed by other write");
  a_reset_safe: assert property (@(posedge pclk) disable iff (1'b0)
    !presetn |-> pin_oe_ff == 21'h0 && fen_ff == '0)
    else $error("pins driven in reset");
  a_sleep_hold: assert property (s_asleep2 |-> $stable(pin_oe_ff) && $stable(pin_out_ff))
    else $error("pins changed in sleep");
  a_wake_raise: assert property (sleeping && |wake_src |=> wake_req && !sleeping)
    else $error("no wake on input event");
  a_sel3_route: assert property (!sleeping && fen_ff[`DIOM_F_SEL3]
    |=> pin_oe_ff[2] && pin_out_ff[2] == $past(serial_select_three))
    else $error("select three not routed");
  a_shared_prio: assert property (!sleeping && fen_ff[`DIOM_F_TBPWM] && fen_ff[`DIOM_F_ANT]
    |=> pin_out_ff[13] == $past(timer_b_pwm_out))
    else $error("pin 13 priority wrong");

endmodule : diom_top

// >>> verilog/diom_defines.svh
// register map, field positions and reset values of the pin multiplexer
`ifndef DIOM_DEFINES_SVH
`define DIOM_DEFINES_SVH
`define DIOM_NPINS 21
`define DIOM_NFUNC 23
`define DIOM_DIR_OFF 12'h000
`define DIOM_OUT_OFF 12'h004
`define DIOM_IN_OFF 12'h008
`define DIOM_PULL_OFF 12'h00c
`define DIOM_FEN_OFF 12'h010
`define DIOM_IEN_OFF 12'h014
`define DIOM_STAT_OFF 12'h018
`define DIOM_CLR_OFF 12'h01c
`define DIOM_CTRL_OFF 12'h020
`define DIOM_PULL_RST 21'h1fffff
`define DIOM_PI_RST 19'h60003
`define DIOM_CTRL_SLEEP 0
`define DIOM_CTRL_SWRST 1
`define DIOM_F_SEL3 0
`define DIOM_F_SEL4 1
`define DIOM_F_RADIO 2
`define DIOM_F_UA 3
`define DIOM_F_JTA 4
`define DIOM_F_TAGATE 5
`define DIOM_F_PCB 6
`define DIOM_F_TACAP 7
`define DIOM_F_SLOWX 8
`define DIOM_F_SLOWE 9
`define DIOM_F_TAPWM 10
`define DIOM_F_TBGATE 11
`define DIOM_F_TCPWM 12
`define DIOM_F_TBCAP 13
`define DIOM_F_ANT 14
`define DIOM_F_AUDIO 15
`define DIOM_F_TWI 16
`define DIOM_F_PSLV 17
`define DIOM_F_UBFLOW 18
`define DIOM_F_UB 19
`define DIOM_F_JTB 20
`define DIOM_F_TBPWM 21
`define DIOM_F_SPARE 22
`endif

// >>> verilog/diom_pkg.sv
// types shared by the pin multiplexer
package diom_pkg;
  typedef logic [20:0] diom_pins_t;
  typedef enum logic [4:0] {
    PI_UA_CTS, PI_UA_RXD, PI_JTCK, PI_JTMS, PI_JTDI, PI_TA_GATE, PI_PCB,
    PI_TA_CAP, PI_SLOW_IN, PI_TB_GATE, PI_TB_CAP, PI_AUD_IN, PI_TW_CLK,
    PI_TW_DAT, PI_PS_CLK, PI_PS_DIN, PI_PS_SEL, PI_UB_CTS, PI_UB_RXD
  } diom_pi_t;
  typedef enum logic {PS_RUN, PS_SLEEP} diom_pwr_t;
endpackage : diom_pkg

// >>> test/diom_pins_model.sv
// external chips on the general pins and the reset pin
`timescale 1ns/1ps
module diom_pins_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [20:0] general_pin_out,
  input wire logic [20:0] general_pin_oe,
  input wire logic [20:0] general_pin_pullup,
  input wire logic [20:0] ext_val,
  input wire logic [20:0] ext_en,
  input wire logic reset_pin_low_oe,
  input wire logic ext_rst,
  output logic [20:0] general_pin_in,
  output logic reset_pin_low_in,
  output logic clash_seen
);
  logic flip_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // floating lines wander so an unknown never settles to a lucky value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip_ff <= 1'b0;
    end else begin
      flip_ff <= ~flip_ff;
    end
  end
  assign general_pin_in = (general_pin_oe & general_pin_out) | (~general_pin_oe & ext_en & ext_val)
    | (~general_pin_oe & ~ext_en & (general_pin_pullup | ({21{flip_ff}} ^ 21'h0aaaaa)));
  // pull-up, either side may pull low
  assign reset_pin_low_in = ~(reset_pin_low_oe | ext_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // both sides driving one pin is a fight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clash_seen <= 1'b0;
    end else if (|(general_pin_oe & ext_en)) begin
      clash_seen <= 1'b1;
    end
  end
endmodule : diom_pins_model

// >>> test/diom_top_tb_top.sv
// bench for the pin multiplexer: apb tasks, scenarios and verdict
`timescale 1ns/1ps
module diom_top_tb_top;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, int_reset_req = 0, ext_rst = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, wake_req, sleep_active, reset_pin_low_in, reset_pin_low_out;
  logic reset_pin_low_oe, ext_reset_seen, err, clash_seen;
  logic [20:0] general_pin_in, general_pin_out, general_pin_oe, general_pin_pullup;
  logic [20:0] ext_val = '0, ext_en = '0;
  logic serial_select_three, serial_select_four, radio_receive_ctrl, radio_transmit_ctrl;
  logic uart_a_rts, uart_a_txd, jtag_tdo, timer_a_pwm_out, slow_crystal_out, timer_c_pwm_out;
  logic timer_b_pwm_out, antenna_div_out, antenna_div_enable, audio_word_select, audio_bit_clock;
  logic audio_data_out, two_wire_clock_oe, two_wire_data_oe, periph_slave_data_out;
  logic periph_slave_irq, uart_b_rts, uart_b_txd;
  logic uart_a_cts, uart_a_rxd, jtag_tck, jtag_tms, jtag_tdi, timer_a_clock_gate, pulse_count_b_in;
  logic timer_a_capture, slow_clock_in, timer_b_clock_gate, timer_b_capture, audio_data_in;
  logic two_wire_clock_in, two_wire_data_in, periph_slave_clock, periph_slave_data_in;
  logic periph_slave_select, uart_b_cts, uart_b_rxd;
  int bad_count = 0, comparisons = 0;
  // pins driven per function bit, all peripheral outputs high, direction all inputs
  localparam logic [20:0] FEN_OE [22] = '{21'h4, 21'h8, 21'hc, 21'h60, 21'h40, 21'h0, 21'h0,
    21'h0, 21'h400, 21'h0, 21'h400, 21'h0, 21'h800, 21'h0, 21'h3000, 21'h61000, 21'hc000,
    21'h48000, 21'h40000, 21'h80000, 21'h80000, 21'h2000};
  always #2.5 pclk = ~pclk;
  diom_top diom_top_inst (.*);
  diom_pins_model diom_pins_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no cycle limit here, a stuck access is left to the watchdog
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic periph(input logic v);
    {serial_select_three, serial_select_four, radio_receive_ctrl, radio_transmit_ctrl, uart_a_rts,
     uart_a_txd, jtag_tdo, timer_a_pwm_out, slow_crystal_out, timer_c_pwm_out, timer_b_pwm_out,
     antenna_div_out, antenna_div_enable, audio_word_select, audio_bit_clock, audio_data_out,
     two_wire_clock_oe, two_wire_data_oe, periph_slave_data_out, periph_slave_irq, uart_b_rts,
     uart_b_txd} <= {22{v}};
  endtask : periph
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(general_pin_oe, 0);
    check(general_pin_pullup, 21'h1fffff);
    apb(0, 12'h00c, 0);
    check(rd, 32'h001fffff);
    apb(0, 12'h010, 0);
    check(rd, 0);
  endtask : t_reset
  task automatic t_gpio();
    apb(1, 12'h000, 32'hf);
    apb(1, 12'h004, 32'h5);
    @(posedge pclk) begin ext_en <= 21'h000f00; ext_val <= 21'h000a00; end
    cyc(5);
    check(general_pin_oe, 21'hf);
    apb(0, 12'h008, 0);
    check(rd, 32'h001ffaf5);
    apb(1, 12'h00c, 32'h5);
    cyc(3);
    check(general_pin_pullup, 21'h5);
    @(posedge pclk) ext_en <= '0;
  endtask : t_gpio
  task automatic t_func();
    apb(1, 12'h000, 0);
    periph(1);
    for (int i = 0; i < 22; i++) begin
      apb(1, 12'h010, 32'h1 << i);
      cyc(3);
      check(general_pin_oe, FEN_OE[i]);
    end
    check(general_pin_pullup, 21'h5);
    periph(0);
    apb(1, 12'h010, 32'h5);
    @(posedge pclk) serial_select_three <= 1;
    cyc(3);
    check(general_pin_out[3:2], 2'b01);
    apb(1, 12'h010, 32'h204000);
    @(posedge pclk) timer_b_pwm_out <= 1;
    cyc(3);
    check(general_pin_out[13:12], 2'b10);
    apb(1, 12'h000, 32'h1fffff);
    apb(1, 12'h010, 32'h8);
    @(posedge pclk) begin ext_en <= 21'h80; ext_val <= 21'h0; end
    cyc(5);
    check(general_pin_oe[7:4], 4'h6);
    check(uart_a_rxd, 0);
    @(posedge pclk) ext_val <= 21'h80;
    cyc(5);
    check(uart_a_rxd, 1);
    @(posedge pclk) ext_en <= '0;
    apb(1, 12'h010, 0);
  endtask : t_func
  task automatic t_irq();
    apb(1, 12'h000, 0);
    // pulled-up lines stay quiet, only pin 8 may raise a status bit
    apb(1, 12'h00c, 32'h1fffff);
    apb(1, 12'h014, 32'h100);
    @(posedge pclk) ext_en <= 21'h100;
    cyc(4);
    apb(1, 12'h01c, 32'h1fffff);
    @(posedge pclk) ext_en <= '0;
    cyc(6);
    check(irq, 1);
    apb(1, 12'h018, 0);
    apb(0, 12'h018, 0);
    check(rd, 32'h100);
    apb(1, 12'h014, 0);
    cyc(2);
    check(irq, 0);
    apb(1, 12'h01c, 32'h100);
    apb(0, 12'h018, 0);
    check(rd, 0);
    apb(0, 12'h01c, 0);
    check(rd, 0);
    apb(0, 12'h024, 0);
    check(rd, 0);
    check(err, 1);
    apb(1, 12'h002, 32'h1);
    check(err, 1);
  endtask : t_irq
  task automatic t_sleep();
    int n;
    n = 0;
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h014, 32'h100);
    @(posedge pclk) ext_en <= 21'h100;
    apb(1, 12'h020, 32'h1);
    cyc(2);
    check(sleep_active, 1);
    apb(1, 12'h004, 0);
    apb(1, 12'h000, 0);
    cyc(3);
    check({general_pin_oe[0], general_pin_out[0]}, 2'b11);
    @(posedge pclk) ext_en <= '0;
    while (wake_req !== 1'b1 && n < 12) begin @(posedge pclk); n++; end
    check(n < 12, 1);
    cyc(3);
    check({sleep_active, general_pin_oe[0], general_pin_out[0]}, 3'b000);
  endtask : t_sleep
  task automatic t_rstpin();
    @(posedge pclk) int_reset_req <= 1;
    cyc(2);
    check(reset_pin_low_oe, 1);
    @(posedge pclk) int_reset_req <= 0;
    cyc(3);
    check({reset_pin_low_oe, reset_pin_low_out}, 2'b00);
    @(posedge pclk) ext_rst <= 1;
    cyc(4);
    check(ext_reset_seen, 1);
    @(posedge pclk) ext_rst <= 0;
    apb(1, 12'h020, 32'h2);
    cyc(2);
    check(reset_pin_low_oe, 1);
    apb(1, 12'h020, 0);
  endtask : t_rstpin
  task automatic t_midreset();
    apb(1, 12'h000, 32'h1fffff);
    apb(1, 12'h00c, 0);
    cyc(3);
    check(clash_seen, 0);
    @(posedge pclk) presetn <= 0;
    #1;
    check(general_pin_oe, 0);
    check(general_pin_pullup, 21'h1fffff);
    check({uart_b_rxd, uart_b_cts, periph_slave_select, periph_slave_data_in, periph_slave_clock,
      two_wire_data_in, two_wire_clock_in, audio_data_in, timer_b_capture, timer_b_clock_gate,
      slow_clock_in, timer_a_capture, pulse_count_b_in, timer_a_clock_gate, jtag_tdi, jtag_tms,
      jtag_tck, uart_a_rxd, uart_a_cts}, 19'h60003);
    cyc(4);
    @(posedge pclk) presetn <= 1;
    cyc(2);
    check(general_pin_pullup, 21'h1fffff);
  endtask : t_midreset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // a hang past about fifty times the expected run is treated as a failure
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    // falling edge at time zero so every flop is reset before the first clock
    presetn <= 0;
    periph(0);
    repeat (4) @(posedge pclk);
    presetn <= 1;
    cyc(1);
    t_reset();
    t_gpio();
    t_func();
    t_irq();
    t_sleep();
    t_rstpin();
    t_midreset();
    check(clash_seen, 0);
    results();
  end
endmodule : diom_top_tb_top
